//--- hw/tirc_dev.sv
// Device end: alert line, reset sources and I2C slave.
//
// Functional notes
// - Hold alert low during power-up if enabled.
// - Release alert by itself after power-up.
// - Refresh indicator outputs within one scan.
// - Host stays off I2C during power-up; tirc_host does not wait, the device ignores the bus.
// - I2C accepted from alert rising edge.
// - Alert updated once per scan period.
// - Button touch or release asserts alert.
// - Proximity found or lost asserts alert.
// - Compensation done asserts alert.
// - Alert asserted during every reset.
// - Any register read clears alert.
// - Host services each alert by reading.
// - Three resets: power-up, pin, software.
// - Pin low holds reset; high restarts.
// - Write DE to FF resets device.
// - Slave address 2B, standard and fast.
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
`include "tirc_map.svh"
module tirc_dev (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // Link.
    tirc_if.dev lnk,
    // Sensing events and settings.
    input wire logic alert_sel,
    input wire logic release_en,
    input wire logic ev_touch,
    input wire logic ev_release,
    input wire logic ev_prox,
    input wire logic ev_prox_lost,
    input wire logic ev_comp_done,
    input wire logic [7:0] status_in,
    // Status.
    output logic ready,
    output logic aoi_refresh,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_we
);
    logic [1:0] scl_s_r, sda_s_r, rst_s_r;
    logic scl_d_r, sda_d_r;
    tirc_pkg::tirc_dev_st_t st_r;
    logic [15:0] cnt_r;
    logic [15:0] scan_r;
    logic pend_r, alert_r, swrst_r, rd_clr_r;
    tirc_pkg::tirc_i2c_st_t i_st_r;
    logic [3:0] bit_r;
    logic [7:0] sh_r;
    logic [1:0] byte_r;
    logic rw_r, ack_r, sda_oe_n_r, sda_bit_r;
    logic scl_rise, scl_fall, start_c, stop_c, scl_q, sda_q;
    logic soft_rst;

    // Two flip-flops on every pin input.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_s_r <= 2'h3;
            sda_s_r <= 2'h3;
            rst_s_r <= 2'h0;
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else if (ce) begin
            scl_s_r <= {scl_s_r[0], lnk.scl_o};
            sda_s_r <= {sda_s_r[0], lnk.sda};
            rst_s_r <= {rst_s_r[0], lnk.hw_reset_pin_n};
            scl_d_r <= scl_s_r[1];
            sda_d_r <= sda_s_r[1];
        end
    end
    assign scl_q = scl_s_r[1];
    assign sda_q = sda_s_r[1];
    assign scl_rise = scl_q & ~scl_d_r;
    assign scl_fall = ~scl_q & scl_d_r;
    assign start_c = scl_q & scl_d_r & sda_d_r & ~sda_q;
    assign stop_c = scl_q & scl_d_r & ~sda_d_r & sda_q;
    assign soft_rst = ~rst_s_r[1] | swrst_r;

    // Power-up sequence, restarted by the pin or software reset.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= tirc_pkg::TIRC_PWRUP;
            cnt_r <= 16'h0000;
        end else if (ce) begin
            if (soft_rst) begin
                st_r <= tirc_pkg::TIRC_PWRUP;
                cnt_r <= 16'h0000;
            end else if (st_r == tirc_pkg::TIRC_PWRUP) begin
                if (cnt_r == 16'(`TIRC_PWRUP_CYC - 1)) begin
                    st_r <= tirc_pkg::TIRC_RUN;
                end
                cnt_r <= cnt_r + 16'h0001;
            end
        end
    end

    // Scan period tick and indicator refresh.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scan_r <= 16'h0000;
            aoi_refresh <= 1'b0;
        end else if (ce) begin
            aoi_refresh <= 1'b0;
            if (st_r != tirc_pkg::TIRC_RUN) begin
                scan_r <= 16'h0000;
            end else if (scan_r == 16'(`TIRC_SCAN_CYC - 1)) begin
                scan_r <= 16'h0000;
                aoi_refresh <= 1'b1;
            end else begin
                scan_r <= scan_r + 16'h0001;
            end
        end
    end

    // Alert: events collect, are shown at the scan tick, read clears.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_r <= 1'b0;
            alert_r <= 1'b1;
            ready <= 1'b0;
        end else if (ce) begin
            ready <= st_r == tirc_pkg::TIRC_RUN;
            if (st_r != tirc_pkg::TIRC_RUN) begin
                alert_r <= 1'b1;
                pend_r <= 1'b0;
            end else if (!ready) begin
                // First running cycle: power-up is over, let the line go.
                alert_r <= 1'b0;
                pend_r <= 1'b0;
            end else begin
                if (ev_touch | (ev_release & release_en)
                        | ev_prox | ev_prox_lost
                        | ev_comp_done) begin
                    pend_r <= 1'b1;
                end else if (aoi_refresh) begin
                    pend_r <= 1'b0;
                end
                if (aoi_refresh & (pend_r | ev_touch | ev_comp_done)) begin
                    alert_r <= 1'b1;
                end else if (rd_clr_r) begin
                    alert_r <= 1'b0;
                end
            end
        end
    end
    assign lnk.alert_o = 1'b0;
    assign lnk.alert_oe_n = ~(alert_r & alert_sel);

    // I2C slave, blind while power-up runs.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            i_st_r <= tirc_pkg::TIRC_IDLE;
            bit_r <= 4'h0;
            sh_r <= 8'h00;
            byte_r <= 2'h0;
            rw_r <= 1'b0;
            ack_r <= 1'b0;
            sda_oe_n_r <= 1'b1;
            sda_bit_r <= 1'b1;
            reg_addr <= 8'h00;
            reg_wdata <= 8'h00;
            reg_we <= 1'b0;
            swrst_r <= 1'b0;
            rd_clr_r <= 1'b0;
        end else if (ce) begin
            reg_we <= 1'b0;
            swrst_r <= 1'b0;
            rd_clr_r <= 1'b0;
            if (st_r != tirc_pkg::TIRC_RUN || stop_c) begin
                i_st_r <= tirc_pkg::TIRC_IDLE;
                sda_oe_n_r <= 1'b1;
            end else if (start_c) begin
                i_st_r <= tirc_pkg::TIRC_BIT;
                bit_r <= 4'h0;
                byte_r <= 2'h0;
                sda_oe_n_r <= 1'b1;
            end else begin
                case (i_st_r)
                    tirc_pkg::TIRC_BIT: begin
                        if (scl_rise && !(rw_r && byte_r != 2'h0)) begin
                            sh_r <= {sh_r[6:0], sda_q};
                            bit_r <= bit_r + 4'h1;
                        end else if (scl_rise) begin
                            bit_r <= bit_r + 4'h1;
                        end
                        if (scl_fall && rw_r && byte_r != 2'h0) begin
                            sda_oe_n_r <= sh_r[7];
                            sh_r <= {sh_r[6:0], 1'b1};
                            if (bit_r == 4'h8) begin
                                sda_oe_n_r <= 1'b1;
                                i_st_r <= tirc_pkg::TIRC_ACK;
                            end
                        end else if (scl_fall && bit_r == 4'h8) begin
                            i_st_r <= tirc_pkg::TIRC_ACK;
                            ack_r <= 1'b1;
                            if (byte_r == 2'h0) begin
                                ack_r <= sh_r[7:1] == `TIRC_I2C_ADDR;
                                rw_r <= sh_r[0];
                                if (sh_r[7:1] == `TIRC_I2C_ADDR && sh_r[0]) begin
                                    rd_clr_r <= 1'b1;
                                    sh_r <= status_in;
                                end
                            end else if (byte_r == 2'h1) begin
                                reg_addr <= sh_r;
                            end else begin
                                reg_wdata <= sh_r;
                                reg_we <= 1'b1;
                                if (reg_addr == `TIRC_SWRST_OFS &&
                                        sh_r == `TIRC_SWRST_KEY) begin
                                    swrst_r <= 1'b1;
                                end
                            end
                            sda_oe_n_r <= ~((byte_r != 2'h0) |
                                (sh_r[7:1] == `TIRC_I2C_ADDR));
                        end
                    end
                    tirc_pkg::TIRC_ACK: begin
                        if (scl_rise && rw_r && byte_r != 2'h0 && sda_q) begin
                            i_st_r <= tirc_pkg::TIRC_IDLE;
                        end else if (scl_fall) begin
                            if (byte_r == 2'h0 && !ack_r) begin
                                i_st_r <= tirc_pkg::TIRC_IDLE;
                                sda_oe_n_r <= 1'b1;
                            end else begin
                                i_st_r <= tirc_pkg::TIRC_BIT;
                                bit_r <= 4'h0;
                                byte_r <= (byte_r == 2'h2) ? 2'h2 : byte_r + 2'h1;
                                sda_oe_n_r <= rw_r ? sh_r[7] : 1'b1;
                                if (rw_r) begin
                                    sh_r <= {sh_r[6:0], 1'b1};
                                    bit_r <= 4'h0;
                                end
                            end
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end
    assign lnk.sda_dev_o = 1'b0;
    assign lnk.sda_dev_oe_n = sda_oe_n_r;
endmodule : tirc_dev

//--- inc/tirc_map.svh
// Constants for the touch alert and reset control link.
`ifndef TIRC_MAP_SVH
`define TIRC_MAP_SVH
`define TIRC_I2C_ADDR 7'h2B
`define TIRC_SWRST_OFS 8'hFF
`define TIRC_SWRST_KEY 8'hDE
`define TIRC_CLK_NS 20
`define TIRC_SCL_HALF_NS 1250
`define TIRC_SCL_HALF_CYC ((`TIRC_SCL_HALF_NS) / (`TIRC_CLK_NS))
`define TIRC_PWRUP_CYC 2000
`define TIRC_SCAN_CYC 1000
`define TIRC_REG_CTRL 4'h0
`define TIRC_REG_STAT 4'h1
`define TIRC_REG_IEN 4'h2
`define TIRC_REG_ICLR 4'h3
`define TIRC_REG_ADDR 4'h4
`define TIRC_REG_WDAT 4'h5
`define TIRC_REG_RDAT 4'h6
`define TIRC_CTRL_GO 0
`define TIRC_CTRL_RD 1
`define TIRC_EV_DONE 0
`define TIRC_EV_NACK 1
`define TIRC_EV_ALERT 2
`endif

//--- inc/tirc_pkg.sv
// Types for the touch alert and reset link: bus states used by both ends, power-up states by the device end only.
package tirc_pkg;
    typedef enum {
        TIRC_IDLE, TIRC_START, TIRC_BIT, TIRC_ACK, TIRC_STOP, TIRC_END
    } tirc_i2c_st_t;
    typedef enum {TIRC_PWRUP, TIRC_RUN} tirc_dev_st_t;
endpackage : tirc_pkg

//--- inc/tirc_if.sv
// Link between the touch device end and the host end.
`timescale 1ns/1ps
interface tirc_if;
    logic scl_o;
    logic sda_host_o;
    logic sda_host_oe_n;
    logic sda_dev_o;
    logic sda_dev_oe_n;
    logic alert_o;
    logic alert_oe_n;
    logic hw_reset_pin_n;
    wire sda = ~((~sda_host_oe_n & ~sda_host_o) | (~sda_dev_oe_n & ~sda_dev_o));
    wire host_alert_n = ~(~alert_oe_n & ~alert_o);
    modport dev (input scl_o, input sda, input hw_reset_pin_n,
        output sda_dev_o, output sda_dev_oe_n, output alert_o,
        output alert_oe_n);
    modport host (output scl_o, output sda_host_o, output sda_host_oe_n,
        output hw_reset_pin_n, input sda, input host_alert_n);
endinterface : tirc_if

//--- hw/tirc_host.sv
// Host end: register port driven I2C master and alert watcher.
`timescale 1ns/1ps
`include "tirc_map.svh"
module tirc_host (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // Link.
    tirc_if.host lnk,
    // Register port.
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    // Interrupt.
    output logic irq
);
    logic [1:0] sda_s_r, al_s_r;
    tirc_pkg::tirc_i2c_st_t st_r;
    logic [7:0] cnt_r;
    logic [1:0] ph_r;
    logic [3:0] bit_r;
    logic [1:0] byte_r;
    logic [8:0] sh_r;
    logic busy_r, rd_op_r, scl_r, sda_r, hw_reset_pin_n_r;
    logic [7:0] a_r, wd_r, rdat_r;
    logic [2:0] stat_r, ien_r;
    logic ev_done, ev_nack;
    logic tick;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sda_s_r <= 2'h3;
            al_s_r <= 2'h3;
        end else if (ce) begin
            sda_s_r <= {sda_s_r[0], lnk.sda};
            al_s_r <= {al_s_r[0], lnk.host_alert_n};
        end
    end
    assign tick = cnt_r == 8'(`TIRC_SCL_HALF_CYC - 1);

    // Master: START, address, register, data or a read byte, STOP.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= tirc_pkg::TIRC_IDLE;
            cnt_r <= 8'h00;
            ph_r <= 2'h0;
            bit_r <= 4'h0;
            byte_r <= 2'h0;
            sh_r <= 9'h1FF;
            scl_r <= 1'b1;
            sda_r <= 1'b1;
            rdat_r <= 8'h00;
            ev_done <= 1'b0;
            ev_nack <= 1'b0;
        end else if (ce) begin
            ev_done <= 1'b0;
            ev_nack <= 1'b0;
            cnt_r <= tick ? 8'h00 : cnt_r + 8'h01;
            if (st_r == tirc_pkg::TIRC_IDLE) begin
                cnt_r <= 8'h00;
                // Busy drops one cycle after done; do not restart then.
                if (busy_r && !ev_done) begin
                    st_r <= tirc_pkg::TIRC_START;
                end
            end else if (tick) begin
                case (st_r)
                    tirc_pkg::TIRC_START: begin
                        sda_r <= 1'b0;
                        st_r <= tirc_pkg::TIRC_BIT;
                        sh_r <= {`TIRC_I2C_ADDR, rd_op_r, 1'b1};
                        bit_r <= 4'h0;
                        byte_r <= 2'h0;
                        ph_r <= 2'h0;
                    end
                    tirc_pkg::TIRC_BIT: begin
                        ph_r <= ph_r + 2'h1;
                        if (ph_r == 2'h0) begin
                            scl_r <= 1'b0;
                        end else if (ph_r == 2'h1) begin
                            sda_r <= sh_r[8];
                        end else if (ph_r == 2'h2) begin
                            scl_r <= 1'b1;
                        end else begin
                            sh_r <= {sh_r[7:0], sda_s_r[1]};
                            bit_r <= bit_r + 4'h1;
                            if (bit_r == 4'h8) begin
                                st_r <= tirc_pkg::TIRC_ACK;
                            end
                        end
                    end
                    tirc_pkg::TIRC_ACK: begin
                        byte_r <= byte_r + 2'h1;
                        bit_r <= 4'h0;
                        if (rd_op_r && byte_r == 2'h1) begin
                            rdat_r <= sh_r[8:1];
                            st_r <= tirc_pkg::TIRC_STOP;
                        end else if (sh_r[0] && !(rd_op_r && byte_r == 2'h1)) begin
                            ev_nack <= 1'b1;
                            st_r <= tirc_pkg::TIRC_STOP;
                        end else if (byte_r == 2'h2) begin
                            st_r <= tirc_pkg::TIRC_STOP;
                        end else begin
                            st_r <= tirc_pkg::TIRC_BIT;
                            sh_r <= rd_op_r ? 9'h1FF :
                                {(byte_r == 2'h0) ? a_r : wd_r, 1'b1};
                        end
                    end
                    tirc_pkg::TIRC_STOP: begin
                        ph_r <= ph_r + 2'h1;
                        if (ph_r == 2'h0) begin
                            scl_r <= 1'b0;
                        end else if (ph_r == 2'h1) begin
                            sda_r <= 1'b0;
                        end else if (ph_r == 2'h2) begin
                            scl_r <= 1'b1;
                        end else begin
                            sda_r <= 1'b1;
                            st_r <= tirc_pkg::TIRC_IDLE;
                            ev_done <= 1'b1;
                        end
                    end
                    default: st_r <= tirc_pkg::TIRC_IDLE;
                endcase
            end
        end
    end
    assign lnk.scl_o = scl_r;
    assign lnk.sda_host_o = 1'b0;
    assign lnk.sda_host_oe_n = sda_r;
    assign lnk.hw_reset_pin_n = hw_reset_pin_n_r;

    // Register port and interrupt status; set wins over clear.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_r <= 1'b0;
            rd_op_r <= 1'b0;
            a_r <= 8'h00;
            wd_r <= 8'h00;
            stat_r <= 3'h0;
            ien_r <= 3'h0;
            rdata <= 8'h00;
            irq <= 1'b0;
            hw_reset_pin_n_r <= 1'b1;
        end else if (ce) begin
            if (ev_done) begin
                busy_r <= 1'b0;
            end
            if (wr && addr == `TIRC_REG_CTRL) begin
                busy_r <= wdata[`TIRC_CTRL_GO] | busy_r;
                rd_op_r <= busy_r ? rd_op_r : wdata[`TIRC_CTRL_RD];
                hw_reset_pin_n_r <= ~wdata[7];
            end else if (wr && addr == `TIRC_REG_IEN) begin
                ien_r <= wdata[2:0];
            end else if (wr && addr == `TIRC_REG_ADDR) begin
                a_r <= wdata;
            end else if (wr && addr == `TIRC_REG_WDAT) begin
                wd_r <= wdata;
            end
            stat_r <= (stat_r & ~((wr && addr == `TIRC_REG_ICLR) ?
                wdata[2:0] : 3'h0)) | {~al_s_r[1], ev_nack, ev_done};
            irq <= |(stat_r & ien_r);
            if (!rd) begin
                rdata <= 8'h00;
            end else if (addr == `TIRC_REG_CTRL) begin
                rdata <= {~hw_reset_pin_n_r, 5'h00, rd_op_r, busy_r};
            end else if (addr == `TIRC_REG_STAT) begin
                rdata <= {5'h00, stat_r};
            end else if (addr == `TIRC_REG_IEN) begin
                rdata <= {5'h00, ien_r};
            end else if (addr == `TIRC_REG_ADDR) begin
                rdata <= a_r;
            end else if (addr == `TIRC_REG_WDAT) begin
                rdata <= wd_r;
            end else if (addr == `TIRC_REG_RDAT) begin
                rdata <= rdat_r;
            end else begin
                rdata <= 8'h00;
            end
        end
    end
endmodule : tirc_host

//--- testbench/tirc_chk.sv
// Assertions on the link between the device end and the host end.
`timescale 1ns/1ps
module tirc_chk (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Link.
    input wire logic scl_o,
    input wire logic sda_dev_oe_n,
    input wire logic alert_o,
    input wire logic alert_oe_n,
    input wire logic host_alert_n,
    input wire logic hw_reset_pin_n,
    // Device status.
    input wire logic alert_sel,
    input wire logic ready,
    input wire logic aoi_refresh
);
    logic [10:0] gap_r;
    logic [8:0] pu_cnt_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Cycles since the last indicator refresh while running.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gap_r <= 11'h000;
        end else if (aoi_refresh || !ready) begin
            gap_r <= 11'h000;
        end else begin
            gap_r <= gap_r + 11'h001;
        end
    end

    // Cycles spent in power-up, saturating.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pu_cnt_r <= 9'h000;
        end else if (ready) begin
            pu_cnt_r <= 9'h000;
        end else if (pu_cnt_r != 9'h1FF) begin
            pu_cnt_r <= pu_cnt_r + 9'h001;
        end
    end

    sequence held_s;
        !host_alert_n && !ready;
    endsequence

    pwrup_hold_a: assert property ($rose(rst_n) && alert_sel |-> held_s [*8])
        else $error("Alert not held low after reset");
    pin_fall_a: assert property ($fell(hw_reset_pin_n) && alert_sel |-> ##[1:6] !host_alert_n)
        else $error("Alert not low on reset pin");
    pin_rise_a: assert property ($rose(hw_reset_pin_n) && alert_sel |-> held_s [*8])
        else $error("No power-up after reset pin");
    od_low_a: assert property (!alert_oe_n |-> !alert_o && alert_sel)
        else $error("Alert line driven high");
    sda_hold_a: assert property (scl_o && $past(scl_o) && ready && $past(ready) |-> $stable(sda_dev_oe_n))
        else $error("Device data moved while clock high");
    ready_rel_a: assert property ($rose(host_alert_n) |-> ready)
        else $error("Not ready after alert release");
    aoi_first_a: assert property ($rose(ready) |-> ##[0:1000] aoi_refresh)
        else $error("No indicator refresh after power-up");
    aoi_gap_a: assert property (ready |-> gap_r <= 11'h3E8)
        else $error("Scan period overrun");
    quiet_pwrup_a: assert property (pu_cnt_r > 9'h12C |-> sda_dev_oe_n)
        else $error("Device answered during power-up");
endmodule : tirc_chk

//--- testbench/touch_irq_reset_control_tb.sv
// Bench joining device and host ends over the link.
`timescale 1ns/1ps
`include "tirc_map.svh"
module touch_irq_reset_control_tb;
    typedef struct packed {
        logic [4:0] ev;
        logic ren;
        logic [7:0] st;
        logic alert;
    } tirc_row_t;
    logic clk, rst_n, ce, alert_sel, release_en, ready, aoi_refresh;
    logic [4:0] ev;
    logic [7:0] status_in, reg_addr, reg_wdata, bus_wdata, bus_rdata, d;
    logic reg_we, bus_wr, bus_rd, irq;
    logic [3:0] bus_addr;
    int n_mismatch = 0;
    int n_compared = 0;
    int cyc = 0;
    int n_we = 0;
    int i, k;
    // Event bits: touch, release, prox, prox lost, compensation done.
    tirc_row_t rows [6] = '{
        {5'h01, 1'b1, 8'h11, 1'b1},
        {5'h02, 1'b1, 8'h22, 1'b1},
        {5'h04, 1'b1, 8'h44, 1'b1},
        {5'h08, 1'b1, 8'h88, 1'b1},
        {5'h10, 1'b1, 8'hA5, 1'b1},
        {5'h02, 1'b0, 8'h5A, 1'b0}};

    tirc_if tirc_if_inst ();
    tirc_dev tirc_dev_inst (.clk(clk), .rst_n(rst_n), .ce(ce),
        .lnk(tirc_if_inst), .alert_sel(alert_sel), .release_en(release_en),
        .ev_touch(ev[0]), .ev_release(ev[1]), .ev_prox(ev[2]),
        .ev_prox_lost(ev[3]), .ev_comp_done(ev[4]), .status_in(status_in),
        .ready(ready), .aoi_refresh(aoi_refresh), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_we(reg_we));
    tirc_host tirc_host_inst (.clk(clk), .rst_n(rst_n), .ce(ce),
        .lnk(tirc_if_inst), .addr(bus_addr), .wdata(bus_wdata),
        .wr(bus_wr), .rd(bus_rd), .rdata(bus_rdata), .irq(irq));
    tirc_chk tirc_chk_inst (.clk(clk), .rst_n(rst_n),
        .scl_o(tirc_if_inst.scl_o), .sda_dev_oe_n(tirc_if_inst.sda_dev_oe_n),
        .alert_o(tirc_if_inst.alert_o), .alert_oe_n(tirc_if_inst.alert_oe_n),
        .host_alert_n(tirc_if_inst.host_alert_n),
        .hw_reset_pin_n(tirc_if_inst.hw_reset_pin_n), .alert_sel(alert_sel),
        .ready(ready), .aoi_refresh(aoi_refresh));

    task automatic test_done();
        $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : test_done

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic bus_write(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        bus_addr <= a;
        bus_wdata <= v;
        bus_wr <= 1'b1;
        @(posedge clk);
        bus_wr <= 1'b0;
    endtask : bus_write

    task automatic bus_read(input logic [3:0] a, output logic [7:0] v);
        @(posedge clk);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge clk);
        bus_rd <= 1'b0;
        #1 v = bus_rdata;
    endtask : bus_read

    // One link transfer; returns the host status once done is seen.
    task automatic xfer(input logic [7:0] ra, input logic [7:0] v,
            input logic rdf, output logic [7:0] st);
        int n;
        bus_write(`TIRC_REG_ICLR, 8'h03);
        bus_write(`TIRC_REG_ADDR, ra);
        bus_write(`TIRC_REG_WDAT, v);
        bus_write(`TIRC_REG_CTRL, {6'h00, rdf, 1'b1});
        st = 8'h00;
        for (n = 0; n < 100 && st[0] !== 1'b1; n++) begin
            repeat (100) @(posedge clk);
            bus_read(`TIRC_REG_STAT, st);
        end
        chk({7'h00, st[0]}, 8'h01);
    endtask : xfer

    // Counts cycles until ready and checks the power-up length.
    task automatic pu_wait(input int lo, input int hi);
        int n;
        n = 0;
        while (ready !== 1'b1 && n < 3000) begin
            @(posedge clk);
            n++;
        end
        #1;
        chk({7'h00, n >= lo && n <= hi}, 8'h01);
        chk({7'h00, tirc_if_inst.host_alert_n}, 8'h01);
    endtask : pu_wait

    initial begin
        clk = 1'b0;
        forever #(`TIRC_CLK_NS / 2) clk = ~clk;
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 90000) begin
            n_mismatch++;
            $display("Error at %0t: run too long", $time);
            test_done();
        end
    end

    always @(posedge clk) begin
        if (reg_we === 1'b1) begin
            n_we++;
        end
    end

    initial begin
        rst_n = 1'b0;
        ce = 1'b1;
        alert_sel = 1'b1;
        release_en = 1'b1;
        ev = 5'h00;
        status_in = 8'h00;
        bus_addr = 4'h0;
        bus_wdata = 8'h00;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        pu_wait(1995, 2010);
        bus_read(4'hF, d);
        chk(d, 8'h00);
        bus_write(`TIRC_REG_IEN, 8'h00);
        xfer(8'h10, 8'h5A, 1'b0, d);
        chk(d & 8'h03, 8'h01);
        chk(reg_addr, 8'h10);
        chk(reg_wdata, 8'h5A);
        chk({7'h00, irq}, 8'h00);
        bus_write(`TIRC_REG_IEN, 8'h01);
        @(posedge clk);
        #1 chk({7'h00, irq}, 8'h01);
        bus_write(`TIRC_REG_ICLR, 8'h01);
        @(posedge clk);
        #1 chk({7'h00, irq}, 8'h00);
        bus_write(`TIRC_REG_STAT, 8'hFF);
        bus_read(`TIRC_REG_STAT, d);
        chk(d & 8'h03, 8'h00);
        bus_write(`TIRC_REG_IEN, 8'h04);
        bus_write(`TIRC_REG_ICLR, 8'h07);
        for (i = 0; i < 6; i++) begin
            release_en <= rows[i].ren;
            status_in <= rows[i].st;
            @(posedge clk);
            ev <= rows[i].ev;
            @(posedge clk);
            ev <= 5'h00;
            k = 0;
            while (tirc_if_inst.host_alert_n !== 1'b0 && k < 1100) begin
                @(posedge clk);
                k++;
            end
            #1;
            chk({7'h00, tirc_if_inst.host_alert_n}, {7'h00, !rows[i].alert});
            // The host sees the alert through two flops, status and irq.
            repeat (4) @(posedge clk);
            #1 chk({7'h00, irq}, {7'h00, rows[i].alert});
            if (rows[i].alert) begin
                xfer(8'h00, 8'h00, 1'b1, d);
                bus_read(`TIRC_REG_RDAT, d);
                chk(d, rows[i].st);
                chk({7'h00, tirc_if_inst.host_alert_n}, 8'h01);
            end
            bus_write(`TIRC_REG_ICLR, 8'h07);
        end
        xfer(`TIRC_SWRST_OFS, 8'h55, 1'b0, d);
        chk(reg_wdata, 8'h55);
        chk({7'h00, ready}, 8'h01);
        xfer(`TIRC_SWRST_OFS, `TIRC_SWRST_KEY, 1'b0, d);
        chk({7'h00, ready}, 8'h00);
        chk({7'h00, tirc_if_inst.host_alert_n}, 8'h00);
        xfer(8'h10, 8'h33, 1'b0, d);
        chk(d & 8'h03, 8'h03);
        pu_wait(0, 2010);
        bus_write(`TIRC_REG_CTRL, 8'h80);
        repeat (2500) @(posedge clk);
        #1 chk({7'h00, ready}, 8'h00);
        chk({7'h00, tirc_if_inst.host_alert_n}, 8'h00);
        bus_write(`TIRC_REG_CTRL, 8'h00);
        pu_wait(1995, 2010);
        alert_sel <= 1'b0;
        @(posedge clk);
        ev <= 5'h01;
        @(posedge clk);
        ev <= 5'h00;
        repeat (1100) @(posedge clk);
        #1 chk({7'h00, tirc_if_inst.host_alert_n}, 8'h01);
        chk(8'(n_we), 8'h03);
        test_done();
    end
endmodule : touch_irq_reset_control_tb
